// ### common/core_regs_pkg.sv
/*
  Package for the core status register block: register addresses, field
  positions, reset values, operation codes and carrier structs.
  Assumes an 8-bit special-function register space addressed by the CPU.
*/
package core_regs_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_PRIMARY = 8'hE0;
  localparam logic [7:0] ADDR_SECOND = 8'hF0;
  // bit-addressable registers sit on addresses with the low three bits zero
  localparam logic [2:0] BIT_ADDR_ALIGN = 3'h0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_LOW = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER_HIGH = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_PRIMARY = 8'h00;
  localparam logic [7:0] RST_SECOND = 8'h00;

  // ----------------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------------
  localparam int POS_CARRY = 7;
  localparam int POS_NIBBLE_CARRY = 6;
  localparam int POS_USER_ZERO = 5;
  localparam int POS_BANK_HI = 4;
  localparam int POS_BANK_LO = 3;
  localparam int POS_RANGE_ERR = 2;
  localparam int POS_USER_ONE = 1;
  localparam int POS_PARITY = 0;
  // bank base address is bank number times the bank size of eight
  localparam logic [7:0] BANK_SIZE = 8'h08;
  localparam logic [7:0] MUL_LIMIT = 8'hFF;

  // ----------------------------------------------------------------------
  // arithmetic operations driven by the execution unit
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_ADDC = 4'h2,
    OP_SUBB = 4'h3,
    OP_MUL = 4'h4,
    OP_DIV = 4'h5,
    OP_INC = 4'h6,
    OP_DEC = 4'h7
  } arith_op_t;

  // special-function register access from the CPU
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr_en;
    logic [2:0] bit_sel;
    logic bit_val;
  } sfr_req_t;

  // arithmetic request from the execution unit
  typedef struct packed {
    logic valid;
    arith_op_t op;
    logic [7:0] operand;
  } arith_req_t;

  // flag outcome of an arithmetic step
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] second;
    logic write_second;
    logic carry;
    logic nibble_carry;
    logic range_err;
    logic touch_carry;
    logic touch_range;
  } arith_res_t;

endpackage : core_regs_pkg

// ### rtl/arith_flags.sv
/*
  Combinational arithmetic unit: computes results and the carry, nibble-carry
  and range-error flags for one operation on the primary and second registers.
  Assumes the caller registers the outcome; no state lives here.
*/
`timescale 1ns/10ps
module arith_flags (
  input wire core_regs_pkg::arith_op_t op_i,
  input wire logic [7:0] primary_i,
  input wire logic [7:0] second_i,
  input wire logic [7:0] operand_i,
  input wire logic carry_i,
  output core_regs_pkg::arith_res_t res_o
);

  // ----------------------------------------------------------------------
  // operation datapath
  // ----------------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [15:0] product;
  logic cin;

  // one process covers every operation so each path assigns all fields
  always_comb begin
    res_o = '0;
    res_o.primary = primary_i;
    res_o.second = second_i;
    sum = 9'h000;
    low_sum = 5'h00;
    product = 16'h0000;
    cin = 1'b0;
    case (op_i)
      core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADDC: begin
        cin = (op_i == core_regs_pkg::OP_ADDC) ? carry_i : 1'b0;
        sum = {1'b0, primary_i} + {1'b0, operand_i} + {8'h00, cin};
        low_sum = {1'b0, primary_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
        res_o.primary = sum[7:0];
        res_o.touch_carry = 1'b1;
        res_o.carry = sum[8];
        res_o.nibble_carry = low_sum[4];
        res_o.touch_range = 1'b1;
        // signed overflow: like signs in, other sign out
        res_o.range_err = (primary_i[7] == operand_i[7]) && (sum[7] != primary_i[7]);
      end
      core_regs_pkg::OP_SUBB: begin
        sum = {1'b0, primary_i} - {1'b0, operand_i} - {8'h00, carry_i};
        low_sum = {1'b0, primary_i[3:0]} - {1'b0, operand_i[3:0]} - {4'h0, carry_i};
        res_o.primary = sum[7:0];
        res_o.touch_carry = 1'b1;
        res_o.carry = sum[8];
        res_o.nibble_carry = low_sum[4];
        res_o.touch_range = 1'b1;
        res_o.range_err = (primary_i[7] != operand_i[7]) && (sum[7] != primary_i[7]);
      end
      core_regs_pkg::OP_MUL: begin
        product = {8'h00, primary_i} * {8'h00, second_i};
        res_o.primary = product[7:0];
        res_o.second = product[15:8];
        res_o.write_second = 1'b1;
        res_o.touch_carry = 1'b1;
        res_o.touch_range = 1'b1;
        res_o.range_err = (product > {8'h00, core_regs_pkg::MUL_LIMIT});
      end
      core_regs_pkg::OP_DIV: begin
        res_o.touch_carry = 1'b1;
        res_o.touch_range = 1'b1;
        res_o.write_second = 1'b1;
        if (second_i == 8'h00) begin
          // result undefined on zero divisor; operands are left standing
          res_o.range_err = 1'b1;
        end else begin
          res_o.primary = primary_i / second_i;
          res_o.second = primary_i % second_i;
          res_o.range_err = 1'b0;
        end
      end
      core_regs_pkg::OP_INC: begin
        res_o.primary = primary_i + 8'h01;
      end
      core_regs_pkg::OP_DEC: begin
        res_o.primary = primary_i - 8'h01;
      end
      default: begin
        res_o.primary = primary_i;
      end
    endcase
  end

endmodule : arith_flags

// ### rtl/cpu_core_status_registers.sv
/*
  Core special-function registers of an 8-bit CPU: stack top pointer, data
  pointer bytes, program status word, primary and second operand registers.
  Assumes the CPU core presents one register access and at most one arithmetic
  step per cycle, and a separate push strobe ahead of each stack store.
*/
//
// Operation
// - stack pointer increments before each push
// - stack pointer resets to 0x07, read/write
// - data pointer bytes reset zero, form 16 bits
// - data pointer addresses external ram and flash
// - carry set on carry or borrow
// - nibble carry tracks lower half carry, borrow
// - bank bits select one of four register banks
// - overflow set on signed add/subtract overflow
// - overflow set when product exceeds 255
// - overflow set on divide by zero
// - overflow otherwise cleared by those instructions
// - parity flag is odd parity of accumulator
// - user flags only software writes them
// - primary register at 0xE0, resets zero
// - second register at 0xF0, resets zero
// - status word reachable on every page
// - unassigned addresses are reserved
`timescale 1ns/10ps
module cpu_core_status_registers (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire core_regs_pkg::sfr_req_t sfr_req_i,
  input wire core_regs_pkg::arith_req_t arith_req_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [2:0] reg_index_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [15:0] data_pointer_o,
  output logic [7:0] program_status_word_o,
  output logic [7:0] primary_arith_register_o,
  output logic [7:0] second_operand_register_o,
  output logic [7:0] bank_reg_addr_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // odd parity of a byte; used for the flag and the read path
  function automatic logic odd_parity(input logic [7:0] value);
    odd_parity = ^value;
  endfunction : odd_parity

  // apply a bit-addressed write to a byte
  function automatic logic [7:0] bit_write(input logic [7:0] value, input logic [2:0] sel,
                                          input logic bitv);
    logic [7:0] tmp;
    tmp = value;
    tmp[sel] = bitv;
    bit_write = tmp;
  endfunction : bit_write

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] stack_top_pointer_ff, nxt_stack_top_pointer;
  logic [7:0] data_pointer_low_ff, nxt_data_pointer_low;
  logic [7:0] data_pointer_high_ff, nxt_data_pointer_high;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] primary_ff, nxt_primary;
  logic [7:0] second_ff, nxt_second;
  logic [7:0] sfr_rdata_ff, nxt_sfr_rdata;
  logic sfr_hit_ff, nxt_sfr_hit;
  logic [7:0] bank_reg_addr_ff, nxt_bank_reg_addr;
  logic [7:0] status_live;
  logic [7:0] primary_after;
  core_regs_pkg::arith_res_t res;
  logic wr_hit, bit_hit, arith_go;

  // ----------------------------------------------------------------------
  // arithmetic datapath
  // ----------------------------------------------------------------------
  arith_flags u_arith (
    .op_i(arith_req_i.op),
    .primary_i(primary_ff),
    .second_i(second_ff),
    .operand_i(arith_req_i.operand),
    .carry_i(status_ff[core_regs_pkg::POS_CARRY]),
    .res_o(res)
  );

  assign arith_go = arith_req_i.valid && (arith_req_i.op != core_regs_pkg::OP_NONE);
  assign wr_hit = sfr_req_i.wr_en;
  // bit writes only reach registers whose address aligns to eight
  assign bit_hit = sfr_req_i.bit_wr_en && (sfr_req_i.addr[2:0] == core_regs_pkg::BIT_ADDR_ALIGN);

  // ----------------------------------------------------------------------
  // next-state logic for all registers
  // ----------------------------------------------------------------------
  // a software write in the same cycle as an arithmetic step wins, since the
  // core only issues one of them per instruction phase
  always_comb begin
    nxt_stack_top_pointer = stack_top_pointer_ff;
    nxt_data_pointer_low = data_pointer_low_ff;
    nxt_data_pointer_high = data_pointer_high_ff;
    nxt_status = status_ff;
    nxt_primary = primary_ff;
    nxt_second = second_ff;
    // stack pointer moves first so the store uses the new top
    if (push_i) begin
      nxt_stack_top_pointer = stack_top_pointer_ff + 8'h01;
    end else if (pop_i) begin
      nxt_stack_top_pointer = stack_top_pointer_ff - 8'h01;
    end
    if (arith_go) begin
      nxt_primary = res.primary;
      if (res.write_second) begin
        nxt_second = res.second;
      end
      if (res.touch_carry) begin
        nxt_status[core_regs_pkg::POS_CARRY] = res.carry;
        nxt_status[core_regs_pkg::POS_NIBBLE_CARRY] = res.nibble_carry;
      end
      if (res.touch_range) begin
        nxt_status[core_regs_pkg::POS_RANGE_ERR] = res.range_err;
      end
    end
    // decoded byte writes; every register answers on all pages
    if (wr_hit) begin
      case (sfr_req_i.addr)
        core_regs_pkg::ADDR_STACK_TOP: nxt_stack_top_pointer = sfr_req_i.wdata;
        core_regs_pkg::ADDR_DATA_POINTER_LOW: nxt_data_pointer_low = sfr_req_i.wdata;
        core_regs_pkg::ADDR_DATA_POINTER_HIGH: nxt_data_pointer_high = sfr_req_i.wdata;
        core_regs_pkg::ADDR_STATUS: nxt_status = sfr_req_i.wdata;
        core_regs_pkg::ADDR_PRIMARY: nxt_primary = sfr_req_i.wdata;
        core_regs_pkg::ADDR_SECOND: nxt_second = sfr_req_i.wdata;
        default: nxt_primary = nxt_primary;
      endcase
    end else if (bit_hit) begin
      case (sfr_req_i.addr)
        core_regs_pkg::ADDR_STATUS: begin
          // user flags change only here or by byte write
          nxt_status = bit_write(status_ff, sfr_req_i.bit_sel, sfr_req_i.bit_val);
        end
        core_regs_pkg::ADDR_PRIMARY: begin
          nxt_primary = bit_write(primary_ff, sfr_req_i.bit_sel, sfr_req_i.bit_val);
        end
        core_regs_pkg::ADDR_SECOND: begin
          nxt_second = bit_write(second_ff, sfr_req_i.bit_sel, sfr_req_i.bit_val);
        end
        default: nxt_second = nxt_second;
      endcase
    end
    // stored parity bit is read-only; the live value overrides it
    nxt_status[core_regs_pkg::POS_PARITY] = odd_parity(nxt_primary);
  end

  // ----------------------------------------------------------------------
  // live status and read path
  // ----------------------------------------------------------------------
  // parity follows the accumulator in the same cycle, no extra latency
  assign primary_after = primary_ff;
  always_comb begin
    status_live = status_ff;
    status_live[core_regs_pkg::POS_PARITY] = odd_parity(primary_after);
  end

  // reserved addresses read zero and report no hit
  always_comb begin
    nxt_sfr_rdata = 8'h00;
    nxt_sfr_hit = 1'b0;
    if (sfr_req_i.rd_en) begin
      nxt_sfr_hit = 1'b1;
      case (sfr_req_i.addr)
        core_regs_pkg::ADDR_STACK_TOP: nxt_sfr_rdata = stack_top_pointer_ff;
        core_regs_pkg::ADDR_DATA_POINTER_LOW: nxt_sfr_rdata = data_pointer_low_ff;
        core_regs_pkg::ADDR_DATA_POINTER_HIGH: nxt_sfr_rdata = data_pointer_high_ff;
        core_regs_pkg::ADDR_STATUS: nxt_sfr_rdata = status_live;
        core_regs_pkg::ADDR_PRIMARY: nxt_sfr_rdata = primary_ff;
        core_regs_pkg::ADDR_SECOND: nxt_sfr_rdata = second_ff;
        default: begin
          nxt_sfr_hit = 1'b0;
          nxt_sfr_rdata = 8'h00;
        end
      endcase
    end
  end

  // bank base plus register index; registered so the output is a flop
  always_comb begin
    nxt_bank_reg_addr = ({6'h00, nxt_status[core_regs_pkg::POS_BANK_HI:core_regs_pkg::POS_BANK_LO]}
                         * core_regs_pkg::BANK_SIZE) + {5'h00, reg_index_i};
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stack_top_pointer_ff <= core_regs_pkg::RST_STACK_TOP;
      data_pointer_low_ff <= core_regs_pkg::RST_DATA_POINTER_LOW;
      data_pointer_high_ff <= core_regs_pkg::RST_DATA_POINTER_HIGH;
      status_ff <= core_regs_pkg::RST_STATUS;
      primary_ff <= core_regs_pkg::RST_PRIMARY;
      second_ff <= core_regs_pkg::RST_SECOND;
      sfr_rdata_ff <= 8'h00;
      sfr_hit_ff <= 1'b0;
      bank_reg_addr_ff <= 8'h00;
    end else begin
      stack_top_pointer_ff <= nxt_stack_top_pointer;
      data_pointer_low_ff <= nxt_data_pointer_low;
      data_pointer_high_ff <= nxt_data_pointer_high;
      status_ff <= nxt_status;
      primary_ff <= nxt_primary;
      second_ff <= nxt_second;
      sfr_rdata_ff <= nxt_sfr_rdata;
      sfr_hit_ff <= nxt_sfr_hit;
      bank_reg_addr_ff <= nxt_bank_reg_addr;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, each straight from a flop
  // ----------------------------------------------------------------------
  assign sfr_rdata_o = sfr_rdata_ff;
  assign sfr_hit_o = sfr_hit_ff;
  assign stack_top_pointer_o = stack_top_pointer_ff;
  assign data_pointer_o = {data_pointer_high_ff, data_pointer_low_ff};
  assign program_status_word_o = status_ff;
  assign primary_arith_register_o = primary_ff;
  assign second_operand_register_o = second_ff;
  assign bank_reg_addr_o = bank_reg_addr_ff;

endmodule : cpu_core_status_registers

// ### sim/core_status_monitor.sv
/*
  Checker for the core status registers: pointer, flag and read relations.
  Assumes it is bound to cpu_core_status_registers, one clock, sync reset.
*/
`timescale 1ns/10ps
module core_status_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire core_regs_pkg::sfr_req_t sfr_req_i,
  input wire core_regs_pkg::arith_req_t arith_req_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [2:0] reg_index_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic [7:0] stack_top_pointer_o,
  input wire logic [15:0] data_pointer_o,
  input wire logic [7:0] program_status_word_o,
  input wire logic [7:0] primary_arith_register_o,
  input wire logic [7:0] second_operand_register_o,
  input wire logic [7:0] bank_reg_addr_o
);
  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  logic [8:0] add_sum;
  logic [4:0] nib_sum;
  logic add_ov;
  logic [15:0] mul_prod;
  logic mul_big;
  logic sw_idle;
  logic mapped;
  logic ptr_wr;
  logic [3:0] opc;
  // expected flag sources; arithmetic only counts when software leaves the registers alone
  assign add_sum = {1'b0, primary_arith_register_o} + {1'b0, arith_req_i.operand};
  assign nib_sum = {1'b0, primary_arith_register_o[3:0]} + {1'b0, arith_req_i.operand[3:0]};
  assign add_ov = (primary_arith_register_o[7] == arith_req_i.operand[7]) &&
                  (add_sum[7] != primary_arith_register_o[7]);
  assign mul_prod = {8'h00, primary_arith_register_o} * {8'h00, second_operand_register_o};
  assign mul_big = |mul_prod[15:8];
  assign sw_idle = !(sfr_req_i.wr_en || sfr_req_i.bit_wr_en);
  assign mapped = sfr_req_i.addr inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  assign ptr_wr = sfr_req_i.wr_en && (sfr_req_i.addr == 8'h81);
  assign opc = (arith_req_i.valid && sw_idle) ? arith_req_i.op : 4'h0;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_push_inc;
    push_i && !ptr_wr |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push step missed");
  property p_pop_dec;
    pop_i && !push_i && !ptr_wr |=> stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01;
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("stack pointer missed pop step");
  property p_ptr_write;
    ptr_wr && !push_i && !pop_i |=> stack_top_pointer_o == $past(sfr_req_i.wdata);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("stack pointer write lost");
  property p_data_pointer_low;
    sfr_req_i.wr_en && sfr_req_i.addr == 8'h82 |=>
      data_pointer_o == {$past(data_pointer_o[15:8]), $past(sfr_req_i.wdata)};
  endproperty
  a_data_pointer_low: assert property (p_data_pointer_low) else $error("data pointer low write wrong");
  property p_add_flags;
    opc == 4'h1 |=> {program_status_word_o[7], primary_arith_register_o} == $past(add_sum) &&
      program_status_word_o[6] == $past(nib_sum[4]) && program_status_word_o[2] == $past(add_ov);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags");
  property p_mul_ov;
    opc == 4'h4 |=> program_status_word_o[2] == $past(mul_big) && !program_status_word_o[7];
  endproperty
  a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong");
  property p_div_zero;
    opc == 4'h5 && second_operand_register_o == 8'h00 |=>
      program_status_word_o[2] && $stable(primary_arith_register_o);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero not flagged");
  property p_parity;
    program_status_word_o[0] == ^primary_arith_register_o;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_user_keep;
    !(!sw_idle && sfr_req_i.addr == 8'hD0) |=>
      $stable({program_status_word_o[5], program_status_word_o[1]});
  endproperty
  a_user_keep: assert property (p_user_keep) else $error("user flag changed");
  property p_bank_addr;
    !$past(rst_i) |-> bank_reg_addr_o == {3'h0, program_status_word_o[4:3], $past(reg_index_i)};
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank register address wrong");
  property p_unmapped_rd;
    sfr_req_i.rd_en && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("reserved address read");
  property p_status_rd;
    sfr_req_i.rd_en && sfr_req_i.addr == 8'hD0 && sw_idle && opc == 4'h0 |=>
      sfr_hit_o && sfr_rdata_o == $past(program_status_word_o);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status word read wrong");

  c_push: cover property (push_i);
  c_mul_big: cover property (opc == 4'h4 && mul_big);
  c_unmapped: cover property (sfr_req_i.rd_en && !mapped);
endmodule : core_status_monitor

bind cpu_core_status_registers core_status_monitor u_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i), .arith_req_i(arith_req_i),
  .push_i(push_i), .pop_i(pop_i), .reg_index_i(reg_index_i), .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o), .stack_top_pointer_o(stack_top_pointer_o),
  .data_pointer_o(data_pointer_o), .program_status_word_o(program_status_word_o),
  .primary_arith_register_o(primary_arith_register_o),
  .second_operand_register_o(second_operand_register_o), .bank_reg_addr_o(bank_reg_addr_o)
);

// ### sim/tb.sv
/*
  Self-checking testbench for the core status registers.
  Assumes the bench plays the CPU core: register accesses, arithmetic, push/pop.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk_i;
  logic rst_i;
  core_regs_pkg::sfr_req_t sfr_req_i;
  core_regs_pkg::arith_req_t arith_req_i;
  logic push_i;
  logic pop_i;
  logic [2:0] reg_index_i;
  logic [7:0] sfr_rdata_o;
  logic sfr_hit_o;
  logic [7:0] stack_top_pointer_o;
  logic [15:0] data_pointer_o;
  logic [7:0] program_status_word_o;
  logic [7:0] primary_arith_register_o;
  logic [7:0] second_operand_register_o;
  logic [7:0] bank_reg_addr_o;
  int err_total;
  int checked;
  logic [59:0] row;
  logic [7:0] mask;
  logic [7:0] addr_tab [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  logic [7:0] rst_tab [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wr_tab [6] = '{8'h5A, 8'h34, 8'h12, 8'h3A, 8'h07, 8'hC3};
  logic [7:0] rb_tab [6] = '{8'h5A, 8'h34, 8'h12, 8'h3B, 8'h07, 8'hC3};
  // op, primary, second, status in, operand, expected primary, second, status
  logic [59:0] arith_tab [11] = '{
    60'h1_7F_00_20_01_80_00_64, 60'h1_FF_00_02_01_00_00_C2, 60'h2_0E_00_80_01_10_00_40,
    60'h3_80_00_00_01_7F_00_44, 60'h3_00_00_22_01_FF_00_E2, 60'h4_10_10_80_00_00_01_04,
    60'h4_05_03_04_00_0F_00_00, 60'h5_10_00_00_00_10_00_04, 60'h5_11_04_84_00_04_01_00,
    60'h6_FF_00_84_00_00_00_84, 60'h7_00_00_40_00_FF_00_40};

  cpu_core_status_registers u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i), .arith_req_i(arith_req_i),
    .push_i(push_i), .pop_i(pop_i), .reg_index_i(reg_index_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_hit_o(sfr_hit_o), .stack_top_pointer_o(stack_top_pointer_o),
    .data_pointer_o(data_pointer_o), .program_status_word_o(program_status_word_o),
    .primary_arith_register_o(primary_arith_register_o),
    .second_operand_register_o(second_operand_register_o), .bank_reg_addr_o(bank_reg_addr_o)
  );

  // ----------------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // kind 0 byte write, 1 read, 2 bit write (data[2:0] bit, data[3] value)
  task automatic sfr(input logic [1:0] kind, input logic [7:0] addr, input logic [7:0] data);
    core_regs_pkg::sfr_req_t r;
    r = '0;
    r.addr = addr;
    r.wdata = data;
    r.wr_en = (kind == 2'h0);
    r.rd_en = (kind == 2'h1);
    r.bit_wr_en = (kind == 2'h2);
    r.bit_sel = data[2:0];
    r.bit_val = data[3];
    @(posedge core_clk_i);
    sfr_req_i <= r;
    @(posedge core_clk_i);
    sfr_req_i <= '0;
    #1;
  endtask : sfr

  // read data and hit are registered at the taking edge, so they are looked at right after it
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
    sfr(2'h1, addr, 8'h00);
    check("read data", sfr_rdata_o, exp);
    check("read hit", {7'h0, sfr_hit_o}, {7'h0, hit});
  endtask : rd

  task automatic alu(input logic [3:0] code, input logic [7:0] opnd);
    @(posedge core_clk_i);
    arith_req_i <= '{valid: 1'b1, op: core_regs_pkg::arith_op_t'(code), operand: opnd};
    @(posedge core_clk_i);
    arith_req_i <= '0;
    #1;
  endtask : alu

  task automatic stk(input logic up, input logic [7:0] exp);
    @(posedge core_clk_i);
    push_i <= up;
    pop_i <= !up;
    @(posedge core_clk_i);
    push_i <= 1'b0;
    pop_i <= 1'b0;
    #1;
    check("stack pointer", stack_top_pointer_o, exp);
  endtask : stk

  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0;
    checked = 0;
    sfr_req_i = '0;
    arith_req_i = '0;
    push_i = 1'b0;
    pop_i = 1'b0;
    reg_index_i = 3'h0;
    rst_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(addr_tab[i], rst_tab[i], 1'b1);
    for (int i = 0; i < 6; i++) sfr(2'h0, addr_tab[i], wr_tab[i]);
    for (int i = 0; i < 6; i++) rd(addr_tab[i], rb_tab[i], 1'b1);
    check("pointer high", data_pointer_o[15:8], 8'h12);
    check("pointer low", data_pointer_o[7:0], 8'h34);
    // stack pointer wraps through the top of the byte
    sfr(2'h0, 8'h81, 8'hFE);
    stk(1'b1, 8'hFF);
    stk(1'b1, 8'h00);
    stk(1'b0, 8'hFF);
    @(posedge core_clk_i);
    reg_index_i <= 3'h5;
    for (int b = 0; b < 4; b++) begin
      sfr(2'h0, 8'hD0, 8'(b << 3));
      @(posedge core_clk_i);
      #1;
      check("bank address", bank_reg_addr_o, 8'(b * 8 + 5));
    end
    // a write to a reserved place must leave the primary register alone; zeros only there
    sfr(2'h0, 8'hE1, 8'h00);
    rd(8'hE1, 8'h00, 1'b0);
    rd(8'h84, 8'h00, 1'b0);
    rd(8'hE0, 8'h07, 1'b1);
    sfr(2'h0, 8'hD0, 8'h00);
    sfr(2'h2, 8'hD0, 8'h0D);
    sfr(2'h2, 8'hD0, 8'h09);
    rd(8'hD0, 8'h23, 1'b1);
    sfr(2'h2, 8'hF0, 8'h0A);
    rd(8'hF0, 8'hC7, 1'b1);
    sfr(2'h2, 8'hE0, 8'h0C);
    rd(8'hE0, 8'h17, 1'b1);
    check("parity even", {7'h0, program_status_word_o[0]}, 8'h00);
    foreach (arith_tab[i]) begin
      row = arith_tab[i];
      sfr(2'h0, 8'hE0, row[55:48]);
      sfr(2'h0, 8'hF0, row[47:40]);
      sfr(2'h0, 8'hD0, row[39:32]);
      mask = (row[59:56] == 4'h4 || row[59:56] == 4'h5) ? 8'hA6 : 8'hE6;
      alu(row[59:56], row[31:24]);
      check("primary", primary_arith_register_o, row[23:16]);
      check("second", second_operand_register_o, row[15:8]);
      check("flags", program_status_word_o & mask, row[7:0]);
      check("parity", {7'h0, program_status_word_o[0]}, {7'h0, ^row[23:16]});
    end
    // second reset in mid-run
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    check("stack after reset", stack_top_pointer_o, 8'h07);
    check("status after reset", program_status_word_o, 8'h00);
    check("pointer after reset", data_pointer_o[15:8], 8'h00);
    rd(8'hE0, 8'h00, 1'b1);
    final_report();
  end
endmodule : tb
